/* hw/spd_dev_end.sv */
// Memory end: two-wire slave serving reads of a 256-byte array
// Notes on behaviour
// - Pointer holds last accessed location plus one
// - Read address byte: acknowledge, send byte at pointer
// - Master nack then stop ends read; release data
// - Random read loads location via write word address
// - Repeated start after word abandons write, pointer kept
// - Read address after repeated start sends loaded byte
// - Master ack requests next consecutive byte
// - Pointer advances by one after every data byte
// - Standby once any operation ends normally
// - Bad address or framing falls back to standby
// - Power-on reset restores every register default
// - Reset clears pointer to location zero
// - Read transfer starts like write, direction bit one
// - Array selected by code 1010 in upper nibble
`default_nettype none
module spd_dev_end
    import spd_pkg::*;
#(
    parameter logic [2:0] SLAVE_SEL = 3'h0
) (
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    spd_link_if.dev     link,
    output var  logic   standby,
    output var  logic [7:0] ptrView
);
    logic        sclMeta;
    logic        sclSync;
    logic        sclDly;
    logic        sdaMeta;
    logic        sdaSync;
    logic        sdaDly;
    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;

    spd_dev_st_t state_reg;
    spd_dev_st_t state_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [7:0]  ptr_reg;
    logic [7:0]  ptr_next;
    logic        rw_reg;
    logic        rw_next;
    logic        ackPh_reg;
    logic        ackPh_next;
    logic        sdaOe_reg;
    logic        sdaOe_next;
    logic        standby_reg;
    logic        memWe;
    logic [7:0]  memRd;
    logic [7:0]  mem [SPD_MEM_BYTES];

    // Link pins are foreign to ref_clk; only the second and third stages are looked at
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclDly  <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaDly  <= 1'b1;
        end else begin
            sclMeta <= link.scl;
            sclSync <= sclMeta;
            sclDly  <= sclSync;
            sdaMeta <= link.sda;
            sdaSync <= sdaMeta;
            sdaDly  <= sdaSync;
        end
    end

    assign sclRise   = sclSync & ~sclDly;
    assign sclFall   = ~sclSync & sclDly;
    assign startCond = sclSync & sclDly & sdaDly & ~sdaSync;
    assign stopCond  = sclSync & sclDly & ~sdaDly & sdaSync;
    assign memRd     = mem[ptr_reg];

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        rw_next    = rw_reg;
        ackPh_next = ackPh_reg;
        sdaOe_next = sdaOe_reg;
        memWe      = 1'b0;
        if (startCond) begin
            // Start or repeated start; a pending write is dropped here
            state_next = DS_ADDR;
            cnt_next   = SPD_BIT_ZERO;
            ackPh_next = 1'b0;
            sdaOe_next = 1'b0;
        end else if (stopCond) begin
            state_next = DS_IDLE;
            ackPh_next = 1'b0;
            sdaOe_next = 1'b0;
        end else if (state_reg != DS_IDLE) begin
            if (sclRise) begin
                if (cnt_reg != SPD_ACK_SLOT) begin
                    // Transmit bytes are not shifted so the sent data stays intact
                    if (state_reg != DS_READ) begin
                        shift_next = {shift_reg[6:0], sdaSync};
                    end
                    cnt_next = 4'(cnt_reg + 4'h1);
                end else begin
                    cnt_next = SPD_BIT_ZERO;
                    if (state_reg == DS_READ && sdaSync) begin
                        state_next = DS_IDLE;
                    end
                end
            end
            if (sclFall) begin
                if (cnt_reg == SPD_ACK_SLOT && !ackPh_reg) begin
                    ackPh_next = 1'b1;
                    unique case (state_reg)
                        DS_ADDR: begin
                            if (shift_reg[7:4] == SPD_DEV_CODE && shift_reg[3:1] == SLAVE_SEL) begin
                                sdaOe_next = 1'b1;
                                rw_next    = shift_reg[0];
                            end else begin
                                // Foreign address or other function: stay silent
                                state_next = DS_IDLE;
                                ackPh_next = 1'b0;
                            end
                        end
                        DS_WORD: begin
                            ptr_next   = shift_reg;
                            sdaOe_next = 1'b1;
                        end
                        DS_WDATA: begin
                            memWe      = 1'b1;
                            ptr_next   = 8'(ptr_reg + 8'h01);
                            sdaOe_next = 1'b1;
                        end
                        DS_READ: begin
                            // Hand the ninth bit to the master
                            sdaOe_next = 1'b0;
                        end
                        DS_IDLE: begin
                            ackPh_next = 1'b0;
                        end
                    endcase
                end else if (cnt_reg == SPD_BIT_ZERO && ackPh_reg) begin
                    ackPh_next = 1'b0;
                    sdaOe_next = 1'b0;
                    if ((state_reg == DS_ADDR && rw_reg == SPD_RD_BIT) || state_reg == DS_READ) begin
                        state_next = DS_READ;
                        shift_next = memRd;
                        ptr_next   = 8'(ptr_reg + 8'h01);
                        sdaOe_next = ~memRd[7];
                    end else if (state_reg == DS_ADDR) begin
                        state_next = DS_WORD;
                    end else if (state_reg == DS_WORD) begin
                        state_next = DS_WDATA;
                    end
                end else if (state_reg == DS_READ && cnt_reg != SPD_ACK_SLOT) begin
                    sdaOe_next = ~shift_reg[3'(4'h7 - cnt_reg)];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= DS_IDLE;
            cnt_reg     <= SPD_BIT_ZERO;
            shift_reg   <= 8'h00;
            ptr_reg     <= SPD_PTR_RST;
            rw_reg      <= SPD_WR_BIT;
            ackPh_reg   <= 1'b0;
            sdaOe_reg   <= 1'b0;
            standby_reg <= 1'b1;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            ptr_reg     <= ptr_next;
            rw_reg      <= rw_next;
            ackPh_reg   <= ackPh_next;
            sdaOe_reg   <= sdaOe_next;
            standby_reg <= (state_next == DS_IDLE);
        end
    end

    // Array contents survive reset, like nonvolatile cells
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[ptr_reg] <= shift_reg;
        end
    end

    assign link.devSdaOut = 1'b0;
    assign link.devSdaOe  = sdaOe_reg;
    assign standby        = standby_reg;
    assign ptrView        = ptr_reg;
endmodule
`default_nettype wire

/* hw/spd_host_end.sv */
// Host end: two-wire master issuing current and random reads into a FIFO
`default_nettype none
module spd_fifo
#(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    output var  logic         inReady,
    input  wire logic [W-1:0] inData,
    output var  logic         outValid,
    input  wire logic         outReady,
    output var  logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] wr_next;
    logic [AW-1:0] rd_reg;
    logic [AW-1:0] rd_next;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push;
    logic          pop;
    logic [W-1:0]  mem [DEPTH];

    assign push = inValid & inReady;
    assign pop  = outValid & outReady;

    always_comb begin
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW + 1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_reg] <= inData;
        end
    end

    assign inReady  = (cnt_reg != (AW + 1)'(DEPTH));
    assign outValid = (cnt_reg != '0);
    assign outData  = mem[rd_reg];
endmodule

module spd_host_end
    import spd_pkg::*;
#(
    parameter logic [2:0] SLAVE_SEL = 3'h0
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    spd_link_if.host        link,
    input  wire logic       cmdValid,
    output var  logic       cmdReady,
    input  wire logic       cmdRandom,
    input  wire logic [7:0] cmdWord,
    input  wire logic [8:0] cmdLen,
    output var  logic       rdValid,
    input  wire logic       rdReady,
    output var  logic [7:0] rdData,
    output var  logic       busy,
    output var  logic       nackErr
);
    logic         sdaMeta;
    logic         sdaSync;
    logic         tick;
    logic         adv;
    logic         fifoReady;
    logic         push;
    logic         txByte;
    logic         last;
    logic [7:0]   addrByte;
    spd_host_st_t state_reg;
    spd_host_st_t state_next;
    spd_seq_t     seq_reg;
    spd_seq_t     seq_next;
    logic [1:0]   q_reg;
    logic [1:0]   q_next;
    logic [3:0]   bit_reg;
    logic [3:0]   bit_next;
    logic [7:0]   shift_reg;
    logic [7:0]   shift_next;
    logic [7:0]   word_reg;
    logic [7:0]   word_next;
    logic [8:0]   remain_reg;
    logic [8:0]   remain_next;
    logic [7:0]   div_reg;
    logic [7:0]   div_next;
    logic         sclLow_reg;
    logic         sclLow_next;
    logic         sdaLow_reg;
    logic         sdaLow_next;
    logic         ackBad_reg;
    logic         ackBad_next;
    logic         err_reg;
    logic         err_next;
    logic         busy_reg;
    logic         cmdReady_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
        end else begin
            sdaMeta <= link.sda;
            sdaSync <= sdaMeta;
        end
    end

    assign tick   = (div_reg == 8'(SPD_QTR_CYC - 1));
    assign txByte = (seq_reg != SQ_RD);
    assign last   = (remain_reg <= 9'h001);
    // Holding SCL low before a new byte is how a full FIFO stalls the link
    assign adv    = tick & ~(state_reg == HS_BIT && seq_reg == SQ_RD && bit_reg == SPD_BIT_ZERO
                             && q_reg == 2'h0 && !fifoReady);
    assign push   = adv && state_reg == HS_BIT && seq_reg == SQ_RD && q_reg == SPD_Q_LAST
                    && bit_reg == SPD_ACK_SLOT;
    assign addrByte = {SPD_DEV_CODE, SLAVE_SEL, (seq_reg == SQ_AW) ? SPD_WR_BIT : SPD_RD_BIT};

    always_comb begin
        state_next  = state_reg;
        seq_next    = seq_reg;
        q_next      = q_reg;
        bit_next    = bit_reg;
        shift_next  = shift_reg;
        word_next   = word_reg;
        remain_next = remain_reg;
        sclLow_next = sclLow_reg;
        sdaLow_next = sdaLow_reg;
        ackBad_next = ackBad_reg;
        err_next    = 1'b0;
        div_next    = tick ? 8'h00 : 8'(div_reg + 8'h01);
        if (state_reg == HS_IDLE) begin
            q_next = 2'h0;
            if (cmdValid) begin
                state_next  = HS_START;
                seq_next    = cmdRandom ? SQ_AW : SQ_AR;
                word_next   = cmdWord;
                remain_next = cmdLen;
            end
        end else if (adv) begin
            q_next = 2'(q_reg + 2'h1);
            unique case (state_reg)
                HS_START: begin
                    unique case (q_reg)
                        2'h0: sdaLow_next = 1'b0;
                        2'h1: sclLow_next = 1'b0;
                        2'h2: sdaLow_next = 1'b1;
                        2'h3: begin
                            sclLow_next = 1'b1;
                            state_next  = HS_BIT;
                            bit_next    = SPD_BIT_ZERO;
                            shift_next  = addrByte;
                        end
                    endcase
                end
                HS_BIT: begin
                    unique case (q_reg)
                        2'h0: begin
                            if (bit_reg != SPD_ACK_SLOT) begin
                                sdaLow_next = txByte & ~shift_reg[3'(4'h7 - bit_reg)];
                            end else begin
                                sdaLow_next = ~txByte & ~last;
                            end
                        end
                        2'h1: sclLow_next = 1'b0;
                        2'h2: begin
                            if (bit_reg != SPD_ACK_SLOT && !txByte) begin
                                shift_next = {shift_reg[6:0], sdaSync};
                            end
                            ackBad_next = txByte & sdaSync;
                        end
                        2'h3: begin
                            sclLow_next = 1'b1;
                            bit_next    = 4'(bit_reg + 4'h1);
                            if (bit_reg == SPD_ACK_SLOT) begin
                                bit_next = SPD_BIT_ZERO;
                                if (ackBad_reg) begin
                                    err_next   = 1'b1;
                                    state_next = HS_STOP;
                                end else begin
                                    unique case (seq_reg)
                                        SQ_AW: begin
                                            seq_next   = SQ_WA;
                                            shift_next = word_reg;
                                        end
                                        SQ_WA: begin
                                            seq_next   = SQ_AR;
                                            state_next = HS_START;
                                        end
                                        SQ_AR: seq_next = SQ_RD;
                                        SQ_RD: begin
                                            remain_next = 9'(remain_reg - 9'h001);
                                            if (last) begin
                                                state_next = HS_STOP;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                HS_STOP: begin
                    unique case (q_reg)
                        2'h0: sdaLow_next = 1'b1;
                        2'h1: sclLow_next = 1'b0;
                        2'h2: sdaLow_next = 1'b0;
                        2'h3: state_next  = HS_IDLE;
                    endcase
                end
                HS_IDLE: q_next = 2'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= HS_IDLE;
            seq_reg    <= SQ_AW;
            q_reg      <= 2'h0;
            bit_reg    <= SPD_BIT_ZERO;
            shift_reg  <= 8'h00;
            word_reg   <= 8'h00;
            remain_reg <= 9'h000;
            div_reg    <= 8'h00;
            sclLow_reg <= 1'b0;
            sdaLow_reg <= 1'b0;
            ackBad_reg <= 1'b0;
            err_reg    <= 1'b0;
            busy_reg     <= 1'b0;
            cmdReady_reg <= 1'b1;
        end else begin
            state_reg  <= state_next;
            seq_reg    <= seq_next;
            q_reg      <= q_next;
            bit_reg    <= bit_next;
            shift_reg  <= shift_next;
            word_reg   <= word_next;
            remain_reg <= remain_next;
            div_reg    <= div_next;
            sclLow_reg <= sclLow_next;
            sdaLow_reg <= sdaLow_next;
            ackBad_reg <= ackBad_next;
            err_reg    <= err_next;
            busy_reg     <= (state_next != HS_IDLE);
            cmdReady_reg <= (state_next == HS_IDLE);
        end
    end

    spd_fifo #(
        .W     (8),
        .DEPTH (SPD_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inValid  (push),
        .inReady  (fifoReady),
        .inData   (shift_reg),
        .outValid (rdValid),
        .outReady (rdReady),
        .outData  (rdData)
    );

    assign link.hostSclOut = 1'b0;
    assign link.hostSclOe  = sclLow_reg;
    assign link.hostSdaOut = 1'b0;
    assign link.hostSdaOe  = sdaLow_reg;
    assign cmdReady        = cmdReady_reg;
    assign busy            = busy_reg;
    assign nackErr         = err_reg;
endmodule
`default_nettype wire

/* inc/spd_link_if.sv */
// Two-wire open-drain link joining host end and memory end
`default_nettype none
interface spd_link_if;
    logic hostSclOut;
    logic hostSclOe;
    logic hostSdaOut;
    logic hostSdaOe;
    logic devSdaOut;
    logic devSdaOe;
    logic scl;
    logic sda;

    // Open drain with pull-up: any enabled driver showing zero pulls low
    assign scl = ~(hostSclOe & ~hostSclOut);
    assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

    modport dev (input scl, input sda, output devSdaOut, output devSdaOe);
    modport host (input sda, output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

/* inc/spd_pkg.sv */
// Shared constants and types for the presence-data serial memory link
`default_nettype none
package spd_pkg;
    // Memory array select code in the address byte
    localparam logic [3:0] SPD_DEV_CODE  = 4'ha;
    localparam logic [7:0] SPD_PTR_RST   = 8'h00;
    localparam int         SPD_MEM_BYTES = 256;
    localparam logic [3:0] SPD_ACK_SLOT  = 4'h8;
    localparam logic [3:0] SPD_BIT_ZERO  = 4'h0;
    localparam logic [1:0] SPD_Q_LAST    = 2'h3;
    localparam logic       SPD_RD_BIT    = 1'b1;
    localparam logic       SPD_WR_BIT    = 1'b0;
    // Serial clock timing, link clock made by the host end
    localparam int         SPD_CLK_NS    = 10;
    localparam int         SPD_SCL_NS    = 160;
    localparam int         SPD_QTR_CYC   = (SPD_SCL_NS + 4 * SPD_CLK_NS - 1) / (4 * SPD_CLK_NS);
    localparam int         SPD_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_WORD, DS_WDATA, DS_READ} spd_dev_st_t;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} spd_host_st_t;
    typedef enum logic [1:0] {SQ_AW, SQ_WA, SQ_AR, SQ_RD} spd_seq_t;
endpackage
`default_nettype wire

/* tb/spd_link_properties.sv */
// Link-level properties of the memory end on the shared two-wire link
`default_nettype none
module spd_link_properties (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       hostSdaOe,
    input wire logic       devSdaOe,
    input wire logic       standby,
    input wire logic [7:0] ptrView
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_RST_DEFAULT: assert property (!$past(rst_n) |-> ptrView == 8'h00 && standby)
        else $error("pointer or standby wrong after reset");
    AST_PTR_IDLE: assert property (standby && $past(standby) |-> $stable(ptrView))
        else $error("pointer moved in standby");
    AST_STBY_RELEASE: assert property (standby |-> !devSdaOe)
        else $error("data driven in standby");
    AST_SDA_LOW_SCL: assert property ($rose(devSdaOe) |=> !scl)
        else $error("data driven near clock high");
    AST_SDA_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(devSdaOe))
        else $error("data changed while clock high");
    AST_STOP_STBY: assert property (scl && $past(scl) && $rose(sda) |-> ##[1:6] standby)
        else $error("no standby after stop");
    AST_START_NOT_DEV: assert property (scl && $past(scl) && $fell(sda) |-> !devSdaOe && hostSdaOe)
        else $error("start not made by host");
    AST_PTR_WRAP: assert property ($past(ptrView) == 8'hff && $changed(ptrView) |-> ptrView == 8'h00)
        else $error("pointer did not wrap to zero");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench joining host and memory ends, plus a pair with mismatched select
`default_nettype none
module tb_top
    import spd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk;
    logic       rst_n;
    logic       cmdValid;
    logic       cmdRandom;
    logic [7:0] cmdWord;
    logic [8:0] cmdLen;
    logic       rdReady;
    logic       cmdReady;
    logic       rdValid;
    logic [7:0] rdData;
    logic       busy;
    logic       nackErr;
    logic       standby;
    logic [7:0] ptrView;
    logic       nackErr2;
    logic       standby2;
    logic [7:0] ptrView2;
    logic       badNack = 1'b0;
    logic       hostNack = 1'b0;
    int         nMismatch = 0;
    int         totalChecks = 0;
    int         n;

    spd_link_if link ();
    spd_link_if link2 ();
    spd_dev_end u_spd_dev_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .standby(standby),
        .ptrView(ptrView));
    spd_host_end u_spd_host_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdRandom(cmdRandom), .cmdWord(cmdWord), .cmdLen(cmdLen), .rdValid(rdValid),
        .rdReady(rdReady), .rdData(rdData), .busy(busy), .nackErr(nackErr));
    // Second pair: memory end answers another select, so every command is refused
    spd_dev_end #(.SLAVE_SEL(3'h5)) u_spd_dev_end_2 (.ref_clk(ref_clk), .rst_n(rst_n), .link(link2),
        .standby(standby2), .ptrView(ptrView2));
    spd_host_end u_spd_host_end_2 (.ref_clk(ref_clk), .rst_n(rst_n), .link(link2), .cmdValid(cmdValid),
        .cmdReady(), .cmdRandom(cmdRandom), .cmdWord(cmdWord), .cmdLen(cmdLen), .rdValid(),
        .rdReady(rdReady), .rdData(), .busy(), .nackErr(nackErr2));
    spd_link_properties u_spd_link_properties (.ref_clk(ref_clk), .rst_n(rst_n), .scl(link.scl),
        .sda(link.sda), .hostSdaOe(link.hostSdaOe), .devSdaOe(link.devSdaOe), .standby(standby),
        .ptrView(ptrView));

    always @(posedge ref_clk) begin
        if (nackErr2 === 1'b1) begin
            badNack <= 1'b1;
        end
        if (nackErr === 1'b1) begin
            hostNack <= 1'b1;
        end
    end

    task automatic checkVal(string what, logic [8:0] exp, logic [8:0] got);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stopTest;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Stall holds the FIFO unread so the host must wait on a full buffer
    task automatic readOp(string name, logic rnd, logic [7:0] word, logic [8:0] len, int stall, output int got);
        int t;
        got = 0;
        t = 0;
        cmdRandom = rnd;
        cmdWord = word;
        cmdLen = len;
        cmdValid = 1'b1;
        @(posedge ref_clk);
        #1;
        cmdValid = 1'b0;
        repeat (stall) begin
            @(posedge ref_clk);
            #1;
        end
        rdReady = 1'b1;
        while ((busy !== 1'b0 || rdValid !== 1'b0) && t < 20000) begin
            if (rdValid === 1'b1) begin
                got++;
            end
            @(posedge ref_clk);
            #1;
            t++;
        end
        rdReady = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        checkVal("standby", 9'h001, {8'h00, standby});
        checkVal("ready busy", 9'h002, {7'h00, cmdReady, busy});
        $display("test done: %s", name);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #400us;
        nMismatch++;
        stopTest();
    end

    initial begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmdRandom = 1'b0;
        cmdWord = 8'h00;
        cmdLen = 9'h000;
        rdReady = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        checkVal("ptr reset", 9'h000, {1'b0, ptrView});
        checkVal("standby reset", 9'h001, {8'h00, standby});
        $display("test done: reset");
        repeat (3) @(posedge ref_clk);
        #1;
        readOp("current", 1'b0, 8'h00, 9'h001, 0, n);
        checkVal("bytes", 9'h001, n[8:0]);
        checkVal("ptr", 9'h001, {1'b0, ptrView});
        readOp("random", 1'b1, 8'h10, 9'h003, 0, n);
        checkVal("bytes", 9'h003, n[8:0]);
        checkVal("ptr", 9'h013, {1'b0, ptrView});
        readOp("current two", 1'b0, 8'h00, 9'h002, 0, n);
        checkVal("ptr", 9'h015, {1'b0, ptrView});
        readOp("wrap", 1'b1, 8'hfe, 9'h003, 0, n);
        checkVal("ptr", 9'h001, {1'b0, ptrView});
        readOp("full fifo", 1'b1, 8'h20, 9'h014, 3000, n);
        checkVal("bytes", 9'h014, n[8:0]);
        checkVal("ptr", 9'h034, {1'b0, ptrView});
        readOp("zero length", 1'b0, 8'h00, 9'h000, 0, n);
        checkVal("bytes", 9'h001, n[8:0]);
        checkVal("ptr", 9'h035, {1'b0, ptrView});
        checkVal("host nack", 9'h000, {8'h00, hostNack});
        checkVal("refused nack", 9'h001, {8'h00, badNack});
        checkVal("refused standby", 9'h001, {8'h00, standby2});
        checkVal("refused ptr", 9'h000, {1'b0, ptrView2});
        rst_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        checkVal("ptr second reset", 9'h000, {1'b0, ptrView});
        $display("test done: second reset");
        stopTest();
    end
endmodule
`default_nettype wire
